//--- hdl/tbpwm_top.sv
// Purpose: timer-based pwm generator with single, half and full bridge outputs
// Assumes: 50 MHz i_clk is the oscillator; avalon-mm slave, waitrequest one cycle
// Notes:   pins are driven through output enables gated by direction bits
// What this block does
// - period is (period+1) times 4 times prescale
// - period match clears timer, sets pin, loads shadow
// - duty is 10 bits: upper reg plus bits 5:4
// - duty writable anytime, shadow loads at match only
// - shadow plus 2-bit latch double buffer duty
// - time base is timer plus two low bits
// - time base equal to duty clears pin
// - high time is duty times osc times prescale
// - duty beyond period leaves output unchanged
// - prescaler divides by 1, 4 or 16
// - resolution reaches 10 bits at period 255
// - sleep freezes timer, prescaler and dead band and holds pins
// - reset restores registers, pins become inputs
// - mode field selects single, half, full bridge
// - polarity selected by channel mode field
// - dead band is 4 oscillator periods per count
// - enable waits for new period before output
// - zero control register releases the pin
// - unused outputs stay free for other functions
// - full bridge forward and reverse pin roles
// - half bridge complement with dead band
`timescale 1ns/1ps
module tbpwm_top
   import tbpwm_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   // avalon-mm slave
   input  wire logic [4:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   input  wire logic [3:0]  i_byteenable,
   output logic      [31:0] o_readdata,
   output logic             o_waitrequest,
   // pwm pins
   output tbpwm_pins_t      o_pin_out,
   output tbpwm_pins_t      o_pin_oe
);

   // registers
   logic [7:0]    ctrl_q;      // mode 7:6, duty low 5:4, channel mode 3:0
   logic [7:0]    duty_q;
   logic [7:0]    shadow_q;
   logic [1:0]    latch_q;
   logic [7:0]    period_q;
   logic [6:0]    tctrl_q;     // postscale 6:3, run 2, prescale 1:0
   logic [7:0]    tcount_q;
   logic [7:0]    dband_q;
   logic [3:0]    dir_q;
   logic          sleep_q;
   logic          match_q;
   logic [3:0]    pre_q;       // prescale counter (clock phase lives in it too)
   logic [1:0]    sub_q;       // extra divide by four for 1:16, time base low bits there
   logic          wait_q;
   logic [31:0]   rdata_q;
   tbpwm_state_t  state_q;
   logic          raw_q;       // modulated pwm before steering
   logic [6:0]    dba_q;       // dead band counters for a and b
   logic [6:0]    dbb_q;
   tbpwm_pins_t   out_q;
   tbpwm_pins_t   oe_q;

   // decoded strobes
   logic          wr_go;
   logic          rd_go;
   logic          run;
   logic [3:0]    pre_last;
   logic          tick;
   logic          step;        // edge at which the 10-bit time base advances
   logic          wrap;
   logic [9:0]    tbase;
   logic [9:0]    duty10;
   logic          active;
   logic          low_act;
   tbpwm_mode_t   mode;

   // prescale counter last value: 00 -> 1:1, 01 -> 1:4, 1x -> 1:16
   function automatic logic [3:0] pre_limit(input logic [1:0] sel);
      case (sel)
         2'b00:   pre_limit = 4'h3;
         2'b01:   pre_limit = 4'hF;
         default: pre_limit = 4'hF;
      endcase
   endfunction : pre_limit

   // a write of the low byte lane to a given offset
   function automatic logic wr_hit(input logic go, input logic [4:0] a, input logic [4:0] off,
                                   input logic be);
      wr_hit = go && (a == off) && be;
   endfunction : wr_hit

   assign wr_go  = i_write && !o_waitrequest;
   assign rd_go  = i_read && !o_waitrequest;
   assign run    = tctrl_q[TBPWM_TCTRL_RUN] && !sleep_q;
   assign active = (ctrl_q[3:2] == 2'b11);                                      // pwm modes 11xx
   assign mode   = tbpwm_mode_t'(ctrl_q[7:6]);
   assign low_act = ctrl_q[1];
   // one oscillator period per prescale unit; 1:16 really counts 4*16=64 - see below
   assign pre_last = pre_limit(tctrl_q[1:0]);
   assign tick   = run && (pre_q == pre_last) && (tctrl_q[1] ? sub_q == 2'b11 : 1'b1);
   assign wrap   = tick && (tcount_q == period_q);
   // time base low bits: clock phase at 1:1, prescaler bits otherwise
   // one low-bit step is one oscillator period times the prescale factor
   assign tbase  = {tcount_q, (tctrl_q[1:0] == 2'b00) ? pre_q[1:0] :
                              (tctrl_q[1] ? sub_q : pre_q[3:2])};
   assign step   = run && ((tctrl_q[1:0] == 2'b00) ? 1'b1 :
                           (tctrl_q[1] ? (pre_q == pre_last) : (pre_q[1:0] == 2'b11)));
   assign duty10 = {shadow_q, latch_q};

   // extra divide by four for the 1:16 setting
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sub_q <= 2'b00;
      end else if (run && tctrl_q[1] && pre_q == pre_last) begin
         sub_q <= sub_q + 2'b01;
      end
   end

   // prescaler and period timer
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pre_q    <= 4'h0;
         tcount_q <= 8'h00;
      end else if (wr_hit(wr_go, i_address, TBPWM_OFF_TCOUNT, i_byteenable[0])) begin
         tcount_q <= i_writedata[7:0];
         pre_q    <= 4'h0;
      end else if (run) begin
         pre_q <= (pre_q == pre_last) ? 4'h0 : pre_q + 4'h1;
         if (wrap) begin
            tcount_q <= 8'h00;
         end else if (tick) begin
            tcount_q <= tcount_q + 8'h01;
         end
      end
   end

   // duty shadow loads only at period match, read-only to software
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         shadow_q <= TBPWM_RST_DUTY;
         latch_q  <= 2'b00;
      end else if (wrap) begin
         shadow_q <= duty_q;
         latch_q  <= ctrl_q[TBPWM_CTRL_DLOW_LO +: 2];
      end
   end

   // start-up: wait for the next period boundary before modulating
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= TBPWM_ST_OFF;
      end else begin
         case (state_q)
            TBPWM_ST_OFF:  if (active) state_q <= TBPWM_ST_WAIT;
            TBPWM_ST_WAIT: if (!active) state_q <= TBPWM_ST_OFF;
                           else if (wrap) state_q <= TBPWM_ST_RUN;
            TBPWM_ST_RUN:  if (!active) state_q <= TBPWM_ST_OFF;
            default:       state_q <= TBPWM_ST_OFF;
         endcase
      end
   end

   // raw pwm: set at match unless duty zero, cleared on time base equal
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         raw_q <= 1'b0;
      end else if (!active) begin
         raw_q <= 1'b0;
      end else if (wrap && (state_q != TBPWM_ST_OFF)) begin
         raw_q <= ({duty_q, ctrl_q[5:4]} != 10'h000);
      // clear on the step that brings the time base to the duty value, so the
      // pin is high for exactly duty steps
      end else if (step && state_q == TBPWM_ST_RUN && tbase + 10'h001 == duty10) begin
         raw_q <= 1'b0;
      end
   end

   // dead band: counts ticks of 4 oscillator periods, a after each rising edge, b after each falling edge
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dba_q <= 7'h00;
         dbb_q <= 7'h00;
      end else if (run) begin
         dba_q <= !raw_q ? 7'h00 : (pre_q[1:0] == TBPWM_PHASE_LAST && dba_q != dband_q[6:0]) ? dba_q + 7'h01 : dba_q;
         dbb_q <= raw_q ? 7'h00 : (pre_q[1:0] == TBPWM_PHASE_LAST && dbb_q != dband_q[6:0]) ? dbb_q + 7'h01 : dbb_q;
      end
   end

   // output steering by mode with polarity, frozen in sleep
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         out_q <= '0;
      end else if (!sleep_q) begin
         tbpwm_pins_t p;
         p = '0;
         case (mode)
            TBPWM_MODE_SINGLE: p.a = raw_q;
            TBPWM_MODE_HALF: begin
               p.a = raw_q && (dba_q == dband_q[6:0]);
               p.b = !raw_q && (dbb_q == dband_q[6:0]) && state_q == TBPWM_ST_RUN;
            end
            TBPWM_MODE_FWD: begin
               p.a = (state_q == TBPWM_ST_RUN);
               p.d = raw_q;
            end
            TBPWM_MODE_REV: begin
               p.c = (state_q == TBPWM_ST_RUN);
               p.b = raw_q;
            end
            default: p = '0;
         endcase
         out_q.a <= p.a ^ (low_act && active);
         out_q.b <= p.b ^ (low_act && active);
         out_q.c <= p.c ^ (low_act && active);
         out_q.d <= p.d ^ (low_act && active);
      end
   end

   // output enables: only pins used by the mode and released by direction
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         oe_q <= '0;
      end else if (!sleep_q) begin
         oe_q.a <= active && !dir_q[0];
         oe_q.b <= active && !dir_q[1] && (mode != TBPWM_MODE_SINGLE);
         oe_q.c <= active && !dir_q[2] && (mode == TBPWM_MODE_FWD || mode == TBPWM_MODE_REV);
         oe_q.d <= active && !dir_q[3] && (mode == TBPWM_MODE_FWD || mode == TBPWM_MODE_REV);
      end
   end

   // software registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q   <= TBPWM_RST_CTRL;
         duty_q   <= TBPWM_RST_DUTY;
         period_q <= TBPWM_RST_PERIOD;
         tctrl_q  <= TBPWM_RST_TCTRL;
         dband_q  <= TBPWM_RST_DBAND;
         dir_q    <= TBPWM_RST_DIR;
         sleep_q  <= 1'b0;
      end else begin
         if (wr_hit(wr_go, i_address, TBPWM_OFF_CTRL, i_byteenable[0]))   ctrl_q   <= i_writedata[7:0];
         if (wr_hit(wr_go, i_address, TBPWM_OFF_DUTY, i_byteenable[0]))   duty_q   <= i_writedata[7:0];
         if (wr_hit(wr_go, i_address, TBPWM_OFF_PERIOD, i_byteenable[0])) period_q <= i_writedata[7:0];
         if (wr_hit(wr_go, i_address, TBPWM_OFF_TCTRL, i_byteenable[0]))  tctrl_q  <= i_writedata[6:0];
         if (wr_hit(wr_go, i_address, TBPWM_OFF_DBAND, i_byteenable[0]))  dband_q  <= i_writedata[7:0];
         if (wr_hit(wr_go, i_address, TBPWM_OFF_MISC, i_byteenable[0])) begin
            sleep_q <= i_writedata[TBPWM_MISC_SLEEP];
            dir_q   <= i_writedata[TBPWM_MISC_DIR_LO +: 4];
         end
      end
   end

   // timer match flag: set wins over a write-one clear
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         match_q <= 1'b0;
      end else if (wrap) begin
         match_q <= 1'b1;
      end else if (wr_go && i_address == TBPWM_OFF_MISC && i_byteenable[1] &&
                   i_writedata[TBPWM_MISC_MATCH]) begin
         match_q <= 1'b0;
      end
   end

   // bus handshake: waitrequest drops for one cycle per request
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((i_read || i_write) && wait_q);
      end
   end
   assign o_waitrequest = wait_q;

   // read data registered when the request is seen, unmapped reads zero
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_q <= 32'h0000_0000;
      end else if (i_read && wait_q) begin
         case (i_address)
            TBPWM_OFF_CTRL:   rdata_q <= {24'h00_0000, ctrl_q};
            TBPWM_OFF_DUTY:   rdata_q <= {24'h00_0000, duty_q};
            TBPWM_OFF_SHADOW: rdata_q <= {24'h00_0000, shadow_q};
            TBPWM_OFF_PERIOD: rdata_q <= {24'h00_0000, period_q};
            TBPWM_OFF_TCTRL:  rdata_q <= {25'h000_0000, tctrl_q};
            TBPWM_OFF_TCOUNT: rdata_q <= {24'h00_0000, tcount_q};
            TBPWM_OFF_DBAND:  rdata_q <= {24'h00_0000, dband_q};
            TBPWM_OFF_MISC:   rdata_q <= {23'h00_0000, match_q, dir_q, 3'b000, sleep_q};
            default:          rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign o_readdata = rdata_q;
   assign o_pin_out  = out_q;
   assign o_pin_oe   = oe_q;

   // checks
   chk_timer_wrap: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wrap |=> tcount_q == 8'h00) else $error("timer not cleared at match");
   chk_shadow_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wrap |=> shadow_q == $past(duty_q)) else $error("shadow not loaded");
   chk_shadow_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !wrap |=> $stable(shadow_q)) else $error("shadow changed off match");
   chk_sleep_freeze: assert property (@(posedge i_clk) disable iff (!i_rstn)
      sleep_q && $past(sleep_q) |=> $stable(tcount_q) && $stable(out_q)) else $error("sleep not frozen");
   chk_zero_release: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ctrl_q == 8'h00 |=> oe_q == '0) else $error("pin not released");
   chk_single_free: assert property (@(posedge i_clk) disable iff (!i_rstn)
      mode == TBPWM_MODE_SINGLE |=> !oe_q.b && !oe_q.c && !oe_q.d) else $error("unused pin driven");
   chk_dir_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
      dir_q[0] |=> !oe_q.a) else $error("pin driven while input");
   chk_time_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
      active && step && state_q == TBPWM_ST_RUN && tbase + 10'h001 == duty10 && !wrap |=> !raw_q)
      else $error("pwm not cleared at duty");
   chk_startup_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      state_q == TBPWM_ST_OFF |=> !raw_q) else $error("partial waveform");

   // period match starts a pulse unless the duty is zero
   chk_wrap_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wrap && active && state_q != TBPWM_ST_OFF && {duty_q, ctrl_q[5:4]} != 10'h000 |=> raw_q)
      else $error("pulse not started at match");
   chk_zero_duty: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wrap && {duty_q, ctrl_q[5:4]} == 10'h000 |=> !raw_q)
      else $error("pulse started with zero duty");

   // waiting for the first period keeps the generator quiet
   chk_wait_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
      state_q == TBPWM_ST_WAIT |-> !raw_q)
      else $error("output before first period");

   // duty beyond the period never clears the pulse
   chk_long_duty: assert property (@(posedge i_clk) disable iff (!i_rstn)
      active && raw_q && !wrap && duty10 > {period_q, 2'b11} |=> raw_q)
      else $error("pulse cleared with duty beyond period");

   // half bridge: the two outputs are never active together
   chk_half_excl: assert property (@(posedge i_clk) disable iff (!i_rstn)
      mode == TBPWM_MODE_HALF && !low_act && !sleep_q |=> !(out_q.a && out_q.b))
      else $error("half bridge overlap");

   // dead band keeps output a inactive until its count is reached
   chk_dband_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      mode == TBPWM_MODE_HALF && !low_act && !sleep_q && dba_q != dband_q[6:0] |=> !out_q.a)
      else $error("dead band too short");

   // full bridge pin roles while running
   chk_fwd_roles: assert property (@(posedge i_clk) disable iff (!i_rstn)
      mode == TBPWM_MODE_FWD && state_q == TBPWM_ST_RUN && !low_act && !sleep_q
      |=> out_q.a && !out_q.b && !out_q.c)
      else $error("forward pin roles wrong");
   chk_rev_roles: assert property (@(posedge i_clk) disable iff (!i_rstn)
      mode == TBPWM_MODE_REV && state_q == TBPWM_ST_RUN && !low_act && !sleep_q
      |=> out_q.c && !out_q.a && !out_q.d)
      else $error("reverse pin roles wrong");

   // waitrequest is low for a single cycle per transfer
   chk_bus_single: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low too long");

   cov_sleep_hold: cover property (@(posedge i_clk) sleep_q && oe_q.a);
   cov_full_fwd: cover property (@(posedge i_clk) mode == TBPWM_MODE_FWD && out_q.d);
   cov_half: cover property (@(posedge i_clk) mode == TBPWM_MODE_HALF && out_q.b);
   cov_wrap_run: cover property (@(posedge i_clk) wrap && state_q == TBPWM_ST_RUN);

endmodule : tbpwm_top

//--- inc/tbpwm_pkg.sv
// Purpose: constants and types for the timer-based pwm with bridge modes
// Assumes: 32-bit avalon-mm register bus, one aligned word per register
// Notes:   register byte offsets and reset values live here only
package tbpwm_pkg;

   // register byte offsets
   localparam logic [4:0] TBPWM_OFF_CTRL   = 5'h00; // channel_control_reg
   localparam logic [4:0] TBPWM_OFF_DUTY   = 5'h04; // duty_upper_reg
   localparam logic [4:0] TBPWM_OFF_SHADOW = 5'h08; // duty_shadow_reg
   localparam logic [4:0] TBPWM_OFF_PERIOD = 5'h0C; // period_value
   localparam logic [4:0] TBPWM_OFF_TCTRL  = 5'h10; // period_timer_control
   localparam logic [4:0] TBPWM_OFF_TCOUNT = 5'h14; // period_timer_count
   localparam logic [4:0] TBPWM_OFF_DBAND  = 5'h18; // deadband_control_reg
   localparam logic [4:0] TBPWM_OFF_MISC   = 5'h1C; // sleep, pin direction, status

   // field positions
   localparam int TBPWM_CTRL_MODE_LO = 6;  // output_mode_field 7:6
   localparam int TBPWM_CTRL_DLOW_LO = 4;  // duty_low_bits 5:4
   localparam int TBPWM_TCTRL_RUN    = 2;  // timer_run_bit
   localparam int TBPWM_MISC_SLEEP   = 0;
   localparam int TBPWM_MISC_DIR_LO  = 4;  // pin_direction_bit a..d at 7:4
   localparam int TBPWM_MISC_MATCH   = 8;  // timer_match_flag, write 1 clears

   // reset values
   localparam logic [7:0] TBPWM_RST_CTRL   = 8'h00;
   localparam logic [7:0] TBPWM_RST_DUTY   = 8'h00;
   localparam logic [7:0] TBPWM_RST_PERIOD = 8'hFF;
   localparam logic [6:0] TBPWM_RST_TCTRL  = 7'h00;
   localparam logic [7:0] TBPWM_RST_DBAND  = 8'h00;
   localparam logic [3:0] TBPWM_RST_DIR    = 4'hF; // all pins input

   // timing: one timer tick is four oscillator periods at prescale 1:1
   localparam int TBPWM_OSC_PER_TICK = 4;
   localparam logic [1:0] TBPWM_PHASE_LAST = 2'(TBPWM_OSC_PER_TICK - 1);

   // output_mode_field encodings
   typedef enum logic [1:0] {
      TBPWM_MODE_SINGLE = 2'b00,
      TBPWM_MODE_FWD    = 2'b01,
      TBPWM_MODE_HALF   = 2'b10,
      TBPWM_MODE_REV    = 2'b11
   } tbpwm_mode_t;

   // start-up state of the generator
   typedef enum logic [2:0] {
      TBPWM_ST_OFF  = 3'b001,
      TBPWM_ST_WAIT = 3'b010,
      TBPWM_ST_RUN  = 3'b100
   } tbpwm_state_t;

   // four bridge outputs travel together
   typedef struct packed {
      logic d;
      logic c;
      logic b;
      logic a;
   } tbpwm_pins_t;

endpackage : tbpwm_pkg

//--- tb/tbpwm_load.sv
// Purpose: load model on the four pwm pins, with pull-downs on every pin
// Assumes: pins are sampled on the rising edge of the oscillator
// Notes:   measures period and high time of out_a in clock cycles
`timescale 1ns/1ps
module tbpwm_load
   import tbpwm_pkg::*;
(
   // clock
   input  wire logic  i_clk,
   // pins from the block
   input  tbpwm_pins_t i_pin_out,
   input  tbpwm_pins_t i_pin_oe,
   // resolved levels and measurements
   output tbpwm_pins_t o_level,
   output int          o_period_a,
   output int          o_high_a
);
   logic prev_q;
   int   per_q;
   int   hi_q;

   // undriven pins fall to the pull-down level
   assign o_level = tbpwm_pins_t'(i_pin_out & i_pin_oe);

   // period between rising edges and length of each high pulse
   always @(posedge i_clk) begin
      prev_q <= o_level.a;
      if (o_level.a && !prev_q) begin
         o_period_a <= per_q;
         per_q      <= 1;
         hi_q       <= 1;
      end else begin
         per_q <= per_q + 1;
         if (o_level.a) hi_q <= hi_q + 1;
      end
      if (!o_level.a && prev_q) o_high_a <= hi_q;
   end
endmodule : tbpwm_load

//--- tb/tbpwm_top_tb_top.sv
// Purpose: self-checking bench for the pwm block
// Assumes: avalon master waits for waitrequest low; loads pull pins down
// Notes:   ordinary cases in a row table, awkward ones written out after
`timescale 1ns/1ps
module tbpwm_top_tb_top
   import tbpwm_pkg::*;
;
   typedef struct {
      logic [1:0] mode; logic [1:0] pre; logic [7:0] pr; logic [9:0] duty;
      logic [6:0] db; logic lo; int ha, hb, hc, hd; logic [3:0] oe;
   } tbpwm_row_t;
   logic        i_clk, i_rstn, i_read, i_write, o_waitrequest;
   logic [4:0]  i_address;
   logic [31:0] i_writedata, o_readdata, rd, t1;
   logic [3:0]  i_byteenable;
   tbpwm_pins_t o_pin_out, o_pin_oe, lvl, snap;
   int          per_a, hi_a, mismatches, n_checks, cyc, pf, p;
   int          c [4];
   tbpwm_row_t  rows [9] = '{
      '{TBPWM_MODE_SINGLE, 2'h0, 8'h03, 10'h006, 7'h00, 1'b0, 6, 0, 0, 0, 4'h1},
      '{TBPWM_MODE_SINGLE, 2'h1, 8'h03, 10'h005, 7'h00, 1'b0, 20, 0, 0, 0, 4'h1},
      '{TBPWM_MODE_SINGLE, 2'h2, 8'h01, 10'h003, 7'h00, 1'b0, 48, 0, 0, 0, 4'h1},
      '{TBPWM_MODE_SINGLE, 2'h0, 8'h03, 10'h000, 7'h00, 1'b0, 0, 0, 0, 0, 4'h1},
      '{TBPWM_MODE_SINGLE, 2'h0, 8'h03, 10'h014, 7'h00, 1'b0, 16, 0, 0, 0, 4'h1},
      '{TBPWM_MODE_SINGLE, 2'h0, 8'h03, 10'h006, 7'h00, 1'b1, 10, 0, 0, 0, 4'h1},
      '{TBPWM_MODE_HALF,   2'h0, 8'h07, 10'h010, 7'h01, 1'b0, 12, 12, 0, 0, 4'h3},
      '{TBPWM_MODE_FWD,    2'h0, 8'h03, 10'h006, 7'h00, 1'b0, 16, 0, 0, 6, 4'hF},
      '{TBPWM_MODE_REV,    2'h0, 8'h03, 10'h006, 7'h00, 1'b0, 0, 6, 16, 0, 4'hF}};
   logic [4:0]  roff [7] = '{TBPWM_OFF_CTRL, TBPWM_OFF_DUTY, TBPWM_OFF_PERIOD, TBPWM_OFF_TCTRL,
                             TBPWM_OFF_DBAND, TBPWM_OFF_MISC, TBPWM_OFF_SHADOW};
   logic [31:0] rval [7] = '{{24'h0, TBPWM_RST_CTRL}, {24'h0, TBPWM_RST_DUTY}, {24'h0, TBPWM_RST_PERIOD},
                             {25'h0, TBPWM_RST_TCTRL}, {24'h0, TBPWM_RST_DBAND}, {24'h0, TBPWM_RST_DIR, 4'h0},
                             32'h0000_0000};

   tbpwm_top tbpwm_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
   tbpwm_load tbpwm_load_i (.i_clk(i_clk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .o_level(lvl),
      .o_period_a(per_a), .o_high_a(hi_a));

   // 50 MHz oscillator
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // hang guard
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         wrap_up();
      end
   end

   task chk_cnt(input string nm, input int e, input int g);
      n_checks++;
      if (e !== g) begin
         mismatches++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_cnt

   task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (e !== g) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_reg

   task chk_pins(input string nm, input tbpwm_pins_t e, input tbpwm_pins_t g);
      n_checks++;
      if (e !== g) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_pins

   // one avalon transfer, held until waitrequest is sampled low
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge i_clk);
      i_address   <= a;
      i_write     <= wr;
      i_read      <= ~wr;
      i_writedata <= wd;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_waitrequest !== 1'b0 && k < 64);
      chk_cnt("bus answer", 1, int'(k < 64));
      r = o_readdata;
      i_read  <= 1'b0;
      i_write <= 1'b0;
   endtask : bus

   task wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, rd);
   endtask : wr

   task rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000, rd);
      chk_reg(nm, e, rd);
   endtask : rdc

   // high cycles of each pin over n clocks
   task count(input int n);
      c = '{0, 0, 0, 0};
      repeat (n) begin
         @(posedge i_clk);
         for (int j = 0; j < 4; j++) c[j] += int'(lvl[j]);
      end
   endtask : count

   task wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up

   // main sequence
   initial begin
      i_rstn = 1'b0; i_read = 1'b0; i_write = 1'b0; i_address = 5'h00;
      i_writedata = 32'h0000_0000; i_byteenable = 4'hF; cyc = 0; mismatches = 0; n_checks = 0;
      repeat (20) @(posedge i_clk);
      chk_pins("oe in reset", 4'h0, o_pin_oe);
      i_rstn <= 1'b1;
      for (int i = 0; i < 7; i++) rdc("reset value", roff[i], rval[i]);
      wr(TBPWM_OFF_MISC, 8'h00);
      foreach (rows[i]) begin
         pf = (rows[i].pre == 2'h0) ? 1 : ((rows[i].pre == 2'h1) ? 4 : 16);
         p  = (int'(rows[i].pr) + 1) * TBPWM_OSC_PER_TICK * pf;
         wr(TBPWM_OFF_TCTRL, 8'h00);
         wr(TBPWM_OFF_TCOUNT, 8'h00);
         wr(TBPWM_OFF_PERIOD, rows[i].pr);
         wr(TBPWM_OFF_DBAND, {1'b0, rows[i].db});
         wr(TBPWM_OFF_DUTY, rows[i].duty[9:2]);
         wr(TBPWM_OFF_CTRL, {rows[i].mode, rows[i].duty[1:0], 2'b11, rows[i].lo, 1'b0});
         wr(TBPWM_OFF_TCTRL, {5'h00, 1'b1, rows[i].pre});
         repeat (3 * p + 20) @(posedge i_clk);
         count(p);
         chk_cnt("high a", rows[i].ha, c[0]);
         chk_cnt("high b", rows[i].hb, c[1]);
         chk_cnt("high c", rows[i].hc, c[2]);
         chk_cnt("high d", rows[i].hd, c[3]);
         chk_pins("enables", tbpwm_pins_t'(rows[i].oe), o_pin_oe);
         if (rows[i].ha > 0 && rows[i].ha < p && rows[i].mode inside {TBPWM_MODE_SINGLE, TBPWM_MODE_HALF}) begin
            chk_cnt("period a", p, per_a);
            chk_cnt("pulse a", rows[i].ha, hi_a);
         end
      end
      // sleep freezes the count and the pin levels
      wr(TBPWM_OFF_MISC, 8'h01);
      bus(1'b0, TBPWM_OFF_TCOUNT, 32'h0000_0000, t1);
      snap = lvl;
      repeat (40) @(posedge i_clk);
      rdc("count in sleep", TBPWM_OFF_TCOUNT, t1);
      chk_pins("pins in sleep", snap, lvl);
      wr(TBPWM_OFF_MISC, 8'h00);
      // shadow loads only at the period match and ignores writes
      wr(TBPWM_OFF_TCTRL, 8'h00);
      wr(TBPWM_OFF_DUTY, 8'h55);
      rdc("shadow held", TBPWM_OFF_SHADOW, 32'h0000_0001);
      wr(TBPWM_OFF_SHADOW, 8'hAA);
      rdc("shadow read only", TBPWM_OFF_SHADOW, 32'h0000_0001);
      wr(TBPWM_OFF_TCTRL, 8'h04);
      repeat (40) @(posedge i_clk);
      rdc("shadow loaded", TBPWM_OFF_SHADOW, 32'h0000_0055);
      rdc("match flag", TBPWM_OFF_MISC, 32'h0000_0100);
      // clearing the control register lets go of the pins
      wr(TBPWM_OFF_CTRL, 8'h00);
      repeat (4) @(posedge i_clk);
      chk_pins("oe released", 4'h0, o_pin_oe);
      // reset in mid-run
      wr(TBPWM_OFF_CTRL, 8'h0C);
      wr(TBPWM_OFF_PERIOD, 8'h10);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk_pins("oe after reset", 4'h0, o_pin_oe);
      i_rstn <= 1'b1;
      rdc("period after reset", TBPWM_OFF_PERIOD, {24'h0, TBPWM_RST_PERIOD});
      wrap_up();
   end
endmodule : tbpwm_top_tb_top
